/* File: pkg/sebs_params.svh */
`ifndef SEBS_PARAMS_SVH
`define SEBS_PARAMS_SVH

// Timing
`define SEBS_CLK_KHZ      25000
`define SEBS_PROG_MS      15

// Register map, byte addresses
`define SEBS_OFS_CTRL     12'h000
`define SEBS_OFS_STATUS   12'h004
`define SEBS_CTRL_EN_BIT  0
`define SEBS_CTRL_EN_RST  1'b1

// Serial framing
`define SEBS_PREFIX       4'ha
`define SEBS_LAST_BIT     4'd7
`define SEBS_ACK_SLOT     4'd8
`define SEBS_ERASED       8'hff
`define SEBS_ADDR_MAX     7'h7f
`define SEBS_LINE_IDLE    3'h7

`endif

/* File: pkg/sebs_pkg.sv */
package sebs_pkg;

	typedef enum logic [2:0]
	{
		SEBS_IDLE   = 3'b000,
		SEBS_SEL    = 3'b001,
		SEBS_ADDR   = 3'b010,
		SEBS_DATA   = 3'b011,
		SEBS_READ   = 3'b100,
		SEBS_IGNORE = 3'b101
	} sebs_state_t;

	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} sebs_apb_req_t;

	typedef struct packed
	{
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} sebs_apb_rsp_t;

	typedef struct packed
	{
		logic [127:0][7:0] mem;
		sebs_state_t       fsm;
		logic [3:0]        bitcnt;
		logic [7:0]        shreg;
		logic [6:0]        addr;
		logic [7:0]        data;
		logic              rd_sel;
		logic              pending;
		logic              unlocked;
		logic              addr_given;
		logic              busy;
		logic              erase_ph;
		logic [18:0]       timer;
		logic              oe;
		logic [2:0]        scl_s;
		logic [2:0]        sda_s;
		logic [2:0]        strap1;
		logic [2:0]        strap2;
		logic              enable;
		sebs_apb_rsp_t     rsp;
	} sebs_regs_t;

endpackage

/* File: hdl/sebs_top.sv */
// Operation
// - Idle bus: both lines high, our data driver released.
// - SDA falling with SCL high is start; SDA rising with SCL high is stop.
// - SDA changes only while SCL low; sampled while SCL high.
// - Transfers are whole eight-bit bytes, each followed by an acknowledge clock.
// - On select match, pull SDA low from eighth clock fall through ninth clock.
// - While reading, release SDA when master leaves acknowledge high.
// - Shortened read: data follows read select, from last used address.
// - Programming starts only on stop after acknowledged data byte.
// - Three select bits compared with three strap inputs.
// - Write select: 1010, select bits two..zero, then 0, then acknowledge.
// - Read select: same as write select but eighth bit is 1.
// - Word address byte: don't-care bit then seven address bits, MSB first.
// - Write data byte MSB first, acknowledged on ninth clock.
// - Read data shifted out MSB first; master acknowledges on ninth clock.
// - Word loaded during ninth select clock; bits driven after each fall.
// - Address counter increments by one on each master acknowledge.
// - Address counter wraps from 127 to 0.
// - Stop during read releases SDA and returns sequencer to idle.
// - Erase/write runs on chip under its own timer, typically 15 ms.
// - Programming erases word to ones, then writes zeros from data byte.
// - Skip write if data has no zeros; skip erase if word already erased.
// - Addressing the device during programming terminates it.
// - After reset, program cycles rejected until a word address read completes.
`timescale 1ns/10ps
`include "sebs_params.svh"

module sebs_top
	import sebs_pkg::*;
#(
	parameter int PROG_CYCLES = `SEBS_PROG_MS * `SEBS_CLK_KHZ
)
(
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic          clk_en,
	input  wire sebs_apb_req_t apb_req,
	output sebs_apb_rsp_t      apb_rsp,
	input  wire logic          scl_in,
	input  wire logic          sda_in,
	output logic               sda_out,
	output logic               sda_oe,
	input  wire logic          select_strap_zero,
	input  wire logic          select_strap_one,
	input  wire logic          select_strap_two_test_input,
	output logic               prog_busy
);

	localparam logic [18:0] PHASE_CYC = 19'(PROG_CYCLES / 2);

	sebs_regs_t r;
	sebs_regs_t n;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;
	logic       sel_match;
	logic       sda_bit;
	logic       apb_setup;
	logic       apb_done;

	function automatic logic [6:0] next_addr(input logic [6:0] a);
		next_addr = (a == `SEBS_ADDR_MAX) ? 7'h00 : 7'(a + 7'h01);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Line events from the synchronised samples

	assign sda_bit   = r.sda_s[1];
	assign scl_rise  = r.scl_s[1] & ~r.scl_s[2];
	assign scl_fall  = ~r.scl_s[1] & r.scl_s[2];
	assign start_ev  = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
	assign stop_ev   = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];
	assign sel_match = r.enable && (r.shreg[7:4] == `SEBS_PREFIX)
		&& (r.shreg[3:1] == r.strap2);
	assign apb_setup = apb_req.psel & ~apb_req.penable;
	assign apb_done  = apb_req.psel & apb_req.penable & r.rsp.pready;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		n = r;
		if (clk_en)
		begin
			n.scl_s  = {r.scl_s[1:0], scl_in};
			n.sda_s  = {r.sda_s[1:0], sda_in};
			n.strap1 = {select_strap_two_test_input, select_strap_one, select_strap_zero};
			n.strap2 = r.strap1;

			// On-chip programming timer
			if (r.busy)
			begin
				if (r.timer != 19'h0)
				begin
					n.timer = 19'(r.timer - 19'h1);
				end
				else if (r.erase_ph)
				begin
					n.mem[r.addr] = `SEBS_ERASED;
					if (r.data != `SEBS_ERASED)
					begin
						n.erase_ph = 1'b0;
						n.timer    = PHASE_CYC;
					end
					else
					begin
						n.busy = 1'b0;
					end
				end
				else
				begin
					n.mem[r.addr] = r.mem[r.addr] & r.data;
					n.busy        = 1'b0;
				end
			end

			// Serial sequencer
			if (start_ev)
			begin
				n.fsm    = SEBS_SEL;
				// All ones: the clock fall that ends the start wraps it to zero
				n.bitcnt = '1;
				n.oe     = 1'b0;
			end
			else if (stop_ev)
			begin
				n.oe         = 1'b0;
				n.fsm        = SEBS_IDLE;
				n.addr_given = 1'b0;
				if (r.pending)
				begin
					n.pending = 1'b0;
					if (r.unlocked)
					begin
						if ((r.mem[r.addr] != `SEBS_ERASED) || (r.data != `SEBS_ERASED))
						begin
							n.busy     = 1'b1;
							n.timer    = PHASE_CYC;
							n.erase_ph = (r.mem[r.addr] != `SEBS_ERASED);
						end
					end
				end
			end
			else
			begin
				unique case (r.fsm)
					SEBS_SEL, SEBS_ADDR, SEBS_DATA:
					begin
						if (scl_rise && (r.bitcnt < `SEBS_ACK_SLOT))
						begin
							n.shreg = {r.shreg[6:0], sda_bit};
						end
						if (scl_rise && (r.bitcnt == `SEBS_ACK_SLOT) && (r.fsm == SEBS_SEL) && r.rd_sel)
						begin
							n.shreg = r.mem[r.addr];
						end
						if (scl_fall)
						begin
							if (r.bitcnt == `SEBS_LAST_BIT)
							begin
								n.bitcnt = `SEBS_ACK_SLOT;
								unique case (r.fsm)
									SEBS_SEL:
									begin
										if (sel_match)
										begin
											n.oe     = 1'b1;
											n.rd_sel = r.shreg[0];
											n.busy   = 1'b0;
										end
										else
										begin
											n.fsm = SEBS_IGNORE;
										end
									end
									SEBS_ADDR:
									begin
										n.addr       = r.shreg[6:0];
										n.addr_given = 1'b1;
										n.oe         = 1'b1;
									end
									default:
									begin
										if (r.pending)
										begin
											n.fsm = SEBS_IGNORE;
										end
										else
										begin
											n.data    = r.shreg;
											n.pending = 1'b1;
											n.oe      = 1'b1;
										end
									end
								endcase
							end
							else if (r.bitcnt == `SEBS_ACK_SLOT)
							begin
								n.oe     = 1'b0;
								n.bitcnt = 4'h0;
								if (r.fsm == SEBS_SEL && r.rd_sel)
								begin
									n.fsm        = SEBS_READ;
									n.oe         = ~r.shreg[7];
									n.unlocked   = r.unlocked | r.addr_given;
									n.addr_given = 1'b0;
								end
								else if (r.fsm == SEBS_SEL)
								begin
									n.fsm = SEBS_ADDR;
								end
								else
								begin
									n.fsm = SEBS_DATA;
								end
							end
							else
							begin
								n.bitcnt = 4'(r.bitcnt + 4'h1);
							end
						end
					end
					SEBS_READ:
					begin
						if (scl_fall)
						begin
							if (r.bitcnt < `SEBS_LAST_BIT)
							begin
								n.shreg  = {r.shreg[6:0], 1'b0};
								n.oe     = ~r.shreg[6];
								n.bitcnt = 4'(r.bitcnt + 4'h1);
							end
							else if (r.bitcnt == `SEBS_LAST_BIT)
							begin
								n.oe     = 1'b0;
								n.bitcnt = `SEBS_ACK_SLOT;
							end
							else
							begin
								n.oe     = ~r.shreg[7];
								n.bitcnt = 4'h0;
							end
						end
						if (scl_rise && (r.bitcnt == `SEBS_ACK_SLOT))
						begin
							if (!sda_bit)
							begin
								n.addr  = next_addr(r.addr);
								n.shreg = r.mem[next_addr(r.addr)];
							end
							else
							begin
								n.fsm = SEBS_IGNORE;
								n.oe  = 1'b0;
							end
						end
					end
					SEBS_IDLE, SEBS_IGNORE:
					begin
						n.oe = 1'b0;
					end
					default:
					begin
						n.fsm = SEBS_IDLE;
						n.oe  = 1'b0;
					end
				endcase
			end

			// Register slave, zero wait states
			n.rsp.pready = apb_setup;
			if (apb_setup)
			begin
				n.rsp.pslverr = 1'b0;
				n.rsp.prdata  = 32'h0;
				if (apb_req.paddr == `SEBS_OFS_CTRL)
				begin
					n.rsp.prdata[`SEBS_CTRL_EN_BIT] = r.enable;
				end
				else if (apb_req.paddr == `SEBS_OFS_STATUS)
				begin
					// busy, unlocked, pending, sequencer state, word address
					n.rsp.prdata = {16'h0, r.busy, r.unlocked, r.pending, 2'h0, r.fsm, 1'b0, r.addr};
				end
				else
				begin
					n.rsp.pslverr = 1'b1;
				end
			end
			if (apb_done && apb_req.pwrite && (apb_req.paddr == `SEBS_OFS_CTRL))
			begin
				n.enable = apb_req.pwdata[`SEBS_CTRL_EN_BIT];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r        <= '0;
			r.mem    <= {128{`SEBS_ERASED}};
			r.scl_s  <= `SEBS_LINE_IDLE;
			r.sda_s  <= `SEBS_LINE_IDLE;
			r.enable <= `SEBS_CTRL_EN_RST;
		end
		else
		begin
			r <= n;
		end
	end

	assign apb_rsp   = r.rsp;
	assign sda_out   = 1'b0;
	assign sda_oe    = r.oe;
	assign prog_busy = r.busy;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk iff clk_en);
	endclocking
	default disable iff (!rst_n);

	sequence sel_byte_done;
		scl_fall && !start_ev && !stop_ev && (r.fsm == SEBS_SEL) && (r.bitcnt == `SEBS_LAST_BIT);
	endsequence

	sequence read_ack_slot;
		scl_rise && !start_ev && !stop_ev && (r.fsm == SEBS_READ) && (r.bitcnt == `SEBS_ACK_SLOT);
	endsequence

	idle_released_a : assert property ((r.fsm == SEBS_IDLE) && !start_ev |=> !r.oe)
		else $error("driver active while idle");

	start_resync_a : assert property (start_ev |=> (r.fsm == SEBS_SEL) && (&r.bitcnt) && !r.oe)
		else $error("start not taken");

	drive_scl_low_a : assert property ($rose(r.oe) |-> !r.scl_s[2])
		else $error("driver engaged while clock high");

	select_ack_a : assert property (sel_byte_done and sel_match |=> r.oe && (r.bitcnt == `SEBS_ACK_SLOT))
		else $error("no acknowledge on select match");

	select_nack_a : assert property (sel_byte_done and !sel_match |=> (r.fsm == SEBS_IGNORE) ##1 !r.oe)
		else $error("mismatched select acknowledged");

	master_nack_a : assert property (read_ack_slot and sda_bit |=> !r.oe && (r.fsm == SEBS_IGNORE))
		else $error("read driver kept after master nack");

	addr_wrap_a : assert property (read_ack_slot and !sda_bit and (r.addr == `SEBS_ADDR_MAX) |=> r.addr == 7'h00)
		else $error("address counter did not wrap");

	addr_step_a : assert property (read_ack_slot and !sda_bit |=> r.addr == 7'($past(r.addr) + 7'h01))
		else $error("address counter did not step");

	stop_idle_a : assert property (stop_ev && (r.fsm == SEBS_READ) |=> (r.fsm == SEBS_IDLE) && !r.oe)
		else $error("stop did not end read");

	locked_prog_a : assert property (stop_ev && r.pending && !r.unlocked && !r.busy |=> !r.busy && !r.pending)
		else $error("program accepted before unlock");

	prog_start_a : assert property (stop_ev && r.pending && r.unlocked && (r.data != `SEBS_ERASED) |=> r.busy[*2])
		else $error("programming not started on stop");

	abort_prog_a : assert property (sel_byte_done and sel_match and r.busy |=> !r.busy)
		else $error("programming not terminated by addressing");

endmodule

/* File: testbench/sebs_master_model.sv */
`timescale 1ns/10ps

module sebs_master_model
(
	output logic      scl,
	output logic      sda,
	input  wire logic dev_oe
);
	logic m_low;

	// Open-drain wire, pull-up when nobody pulls
	assign sda = !(m_low | dev_oe);

	initial
	begin
		scl = 1'b1;
		m_low = 1'b0;
	end

	////////////////////////////////////////
	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		#100 m_low = !b;
		#80 scl = 1'b1;
		#80 r = sda;
		#40 scl = 1'b0;
		#20;
	endtask

	task automatic start;
		#100 m_low = 1'b0;
		#80 scl = 1'b1;
		#160 m_low = 1'b1;
		#120 scl = 1'b0;
		#20;
	endtask

	task automatic stop;
		#100 m_low = 1'b1;
		#80 scl = 1'b1;
		#160 m_low = 1'b0;
		#300;
	endtask

	// Whole byte MSB first, then the acknowledge clock
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(a, k);
	endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps

module tb_top
	import sebs_pkg::*;
();
	logic          mclk;
	logic          rst_n;
	sebs_apb_req_t req;
	sebs_apb_rsp_t rsp;
	logic          scl;
	logic          sda;
	logic          sda_oe;
	logic          busy;
	logic [2:0]    cs;
	logic [31:0]   q;
	logic          e;
	int            fails;
	int            n_checks;

	sebs_master_model m (.scl(scl), .sda(sda), .dev_oe(sda_oe));

	sebs_top #(.PROG_CYCLES(400)) uut (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
		.apb_req(req), .apb_rsp(rsp), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe(sda_oe), .select_strap_zero(cs[0]), .select_strap_one(cs[1]),
		.select_strap_two_test_input(cs[2]), .prog_busy(busy));

	initial
		mclk = 1'b0;
	always
		#20 mclk = ~mclk;

	////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 16);
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		if (rsp.pready !== 1'b1)
		begin
			fails++;
			end_of_test();
		end
	endtask

	task automatic wb(input logic [7:0] b, input logic ak);
		logic [7:0] r;
		logic       k;
		m.xfer(b, 1'b1, r, k);
		chk("ack", 32'(ak), 32'(k));
	endtask

	task automatic sel(input logic rw, input logic [2:0] c, input logic ak);
		wb({4'ha, c, rw}, ak);
	endtask

	task automatic rbyte(input logic [7:0] x, input logic mack);
		logic [7:0] r;
		logic       k;
		m.xfer(8'hff, mack, r, k);
		chk("read data", 32'(x), 32'(r));
	endtask

	task automatic fread(input logic [6:0] a);
		m.start();
		sel(1'b0, cs, 1'b0);
		wb({1'b1, a}, 1'b0);
		m.start();
		sel(1'b1, cs, 1'b0);
	endtask

	task automatic prog(input logic [6:0] a, input logic [7:0] d);
		m.start();
		sel(1'b0, cs, 1'b0);
		wb({1'b0, a}, 1'b0);
		wb(d, 1'b0);
		m.stop();
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 1000)
		begin
			@(posedge mclk);
			n++;
		end
		chk("busy end", 32'h0, 32'(busy));
		if (n >= 1000)
			end_of_test();
	endtask

	////////////////////////////////////////
	initial
	begin
		fails = 0;
		n_checks = 0;
		rst_n = 1'b0;
		req = '0;
		cs = 3'h5;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl", 32'h1, q);
		apb(1'b0, 12'h008, 32'h0);
		chk("slverr", 32'h1, 32'(e));
		prog(7'h7f, 8'h3c);
		chk("locked busy", 32'h0, 32'(busy));
		fread(7'h7f);
		rbyte(8'hff, 1'b1);
		#200 chk("nack oe", 32'h0, 32'(sda_oe));
		m.stop();
		prog(7'h7f, 8'h3c);
		chk("busy", 32'h1, 32'(busy));
		wait_idle();
		prog(7'h00, 8'h5a);
		wait_idle();
		fread(7'h7f);
		rbyte(8'h3c, 1'b0);
		rbyte(8'h5a, 1'b1);
		m.stop();
		chk("stop oe", 32'h0, 32'(sda_oe));
		apb(1'b0, 12'h004, 32'h0);
		chk("state", 32'h0, 32'(q[10:8]));
		chk("counter", 32'h0, 32'(q[6:0]));
		chk("status flags", 32'h2, 32'(q[15:13]));
		m.start();
		sel(1'b1, cs, 1'b0);
		rbyte(8'h5a, 1'b1);
		#200 chk("nack release", 32'h0, 32'(sda_oe));
		m.stop();
		m.start();
		sel(1'b0, 3'h4, 1'b1);
		wb(8'h00, 1'b1);
		m.stop();
		m.start();
		wb(8'h5a, 1'b1);
		m.stop();
		apb(1'b1, 12'h000, 32'h0);
		m.start();
		sel(1'b0, cs, 1'b1);
		m.stop();
		apb(1'b1, 12'h000, 32'h1);
		prog(7'h01, 8'h00);
		chk("busy", 32'h1, 32'(busy));
		m.start();
		sel(1'b0, cs, 1'b0);
		chk("aborted", 32'h0, 32'(busy));
		m.stop();
		prog(7'h7f, 8'hc3);
		chk("erase busy", 32'h1, 32'(busy));
		wait_idle();
		fread(7'h7f);
		rbyte(8'hc3, 1'b0);
		rbyte(8'h5a, 1'b0);
		m.stop();
		chk("read stop oe", 32'h0, 32'(sda_oe));
		apb(1'b0, 12'h004, 32'h0);
		chk("read stop state", 32'h0, 32'(q[10:8]));
		chk("counter step", 32'h1, 32'(q[6:0]));
		prog(7'h7f, 8'hff);
		chk("erase only busy", 32'h1, 32'(busy));
		wait_idle();
		fread(7'h7f);
		rbyte(8'hff, 1'b1);
		m.stop();
		end_of_test();
	end
endmodule
